/* File: rtl/t2c_pkg.sv */
// Package: register map, field positions and reset values for timer 2
package t2c_pkg;

  // ------------------------------------------------------------------
  // Special function register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER0_LOW_BYTE = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_LOW_BYTE = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_HIGH_BYTE = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_HIGH_BYTE = 8'h8d;
  localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_CAPTURE_LOW = 8'hca;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_CAPTURE_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_TIMER2_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_TIMER2_COUNT_HIGH = 8'hcd;

  // ------------------------------------------------------------------
  // Control register bit positions
  // ------------------------------------------------------------------
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_EXTERNAL_EVENT_FLAG = 6;
  localparam int BIT_RX_CLOCK_SELECT = 5;
  localparam int BIT_TX_CLOCK_SELECT = 4;
  localparam int BIT_EXTERNAL_TRIGGER_ENABLE = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNTER_SELECT = 1;
  localparam int BIT_CAPTURE_SELECT = 0;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int COUNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int PIN_N = 2;
  localparam int PIN_TRIGGER = 0;
  localparam int PIN_COUNT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [1:0] PIN_IDLE = 2'h3;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage : t2c_pkg

/* File: rtl/t2c_pin_sync.sv */
// Two-stage synchroniser and falling edge detector for the timer 2 pins
`timescale 1ns/1ns
module t2c_pin_sync
  import t2c_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [PIN_N-1:0] pins, // Raw pin levels
  output logic [PIN_N-1:0] fall // One-cycle pulse per falling edge
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [PIN_N-1:0] meta; // First stage, read only by the second
    logic [PIN_N-1:0] sync; // Second stage
    logic [PIN_N-1:0] prev; // Previous synchronised sample
  } t2c_sync_s;

  t2c_sync_s st_r;
  t2c_sync_s st_nxt;

  // Shift the pins through the stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pins;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  // Idle high so that reset release gives no false edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{meta: PIN_IDLE, sync: PIN_IDLE, prev: PIN_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Edge detect on two successive synchronised samples
  for (genvar i = 0; i < PIN_N; i++) begin : g_fall
    assign fall[i] = st_r.prev[i] & ~st_r.sync[i];
  end

endmodule : t2c_pin_sync

/* File: rtl/t2c_timer2.sv */
// Timer/counter 2 with capture, auto-reload and baud clock, plus timer 0/1 data bytes
`timescale 1ns/1ns
module t2c_timer2
  import t2c_pkg::*;
(
  input wire logic clock, // Core clock, 10 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe, one cycle
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic sfr_rd, // Read strobe, one cycle
  output logic [7:0] sfr_rdata, // Read data, valid the cycle after the strobe
  input wire logic trigger_input, // External trigger pin
  input wire logic count_input, // External count pin
  input wire logic timer1_overflow, // Timer 1 overflow pulse
  output logic rx_baud_tick, // Serial receive clock pulse
  output logic tx_baud_tick, // Serial transmit clock pulse
  output logic overflow_flag, // Overflow flag level, interrupt request
  output logic external_event_flag, // External flag level, interrupt request
  output logic overflow_pulse // One-cycle pulse per timer 2 overflow
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer0_low_byte;
    logic [7:0] timer0_high_byte;
    logic [7:0] timer1_low_byte;
    logic [7:0] timer1_high_byte;
    logic [7:0] timer2_control;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [15:0] count;
    logic [7:0] rdata;
    logic rx_tick;
    logic tx_tick;
    logic ovf_pulse;
  } t2c_state_s;

  t2c_state_s st_r;
  t2c_state_s st_nxt;
  logic [PIN_N-1:0] pin_fall;

  // ------------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------------
  t2c_pin_sync t2c_pin_sync_inst (
    .clock(clock),
    .rst(rst),
    .pins({count_input, trigger_input}),
    .fall(pin_fall)
  );

  // ------------------------------------------------------------------
  // Decoded control fields and events
  // ------------------------------------------------------------------
  logic rx_sel;
  logic tx_sel;
  logic baud_mode;
  logic trig_en;
  logic run;
  logic cnt_sel;
  logic cap_sel;
  logic count_en;
  logic ovf;
  logic trig_edge;
  logic do_capture;
  logic do_reload;
  logic ext_set;
  logic ovf_set;
  logic [15:0] reload_val;

  assign rx_sel = st_r.timer2_control[BIT_RX_CLOCK_SELECT];
  assign tx_sel = st_r.timer2_control[BIT_TX_CLOCK_SELECT];
  assign baud_mode = rx_sel | tx_sel;
  assign trig_en = st_r.timer2_control[BIT_EXTERNAL_TRIGGER_ENABLE];
  assign run = st_r.timer2_control[BIT_RUN];
  assign cnt_sel = st_r.timer2_control[BIT_COUNTER_SELECT];
  assign cap_sel = st_r.timer2_control[BIT_CAPTURE_SELECT];
  assign reload_val = {st_r.reload_high, st_r.reload_low};

  // Counting source and run gate
  assign count_en = run & (cnt_sel ? pin_fall[PIN_COUNT] : 1'b1);
  // Overflow on the step from all ones to zero
  assign ovf = count_en & (st_r.count == COUNT_ALL_ONES);
  // Trigger edges act only when enabled
  assign trig_edge = trig_en & pin_fall[PIN_TRIGGER];
  // Capture only outside baud mode
  assign do_capture = trig_edge & cap_sel & ~baud_mode;
  // Reload on overflow unless capturing; trigger reload outside baud mode
  assign do_reload = (ovf & (~cap_sel | baud_mode))
                   | (trig_edge & ~cap_sel & ~baud_mode);
  // External flag also sets in baud mode, where the edge does nothing else
  assign ext_set = trig_edge;
  // Overflow flag is suppressed in baud mode
  assign ovf_set = ovf & ~baud_mode;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf_pulse = ovf;
    // Serial clock routing
    st_nxt.rx_tick = rx_sel ? ovf : timer1_overflow;
    st_nxt.tx_tick = tx_sel ? ovf : timer1_overflow;
    // Count advance, reload or capture
    if (do_reload) begin
      st_nxt.count = reload_val;
    end else if (count_en) begin
      st_nxt.count = st_r.count + COUNT_ONE;
    end
    if (do_capture) begin
      st_nxt.reload_low = st_r.count[BYTE_W-1:0];
      st_nxt.reload_high = st_r.count[COUNT_W-1:BYTE_W];
    end
    // Software writes win over hardware updates of data bytes
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_TIMER0_LOW_BYTE: begin
          st_nxt.timer0_low_byte = sfr_wdata;
        end
        ADDR_TIMER0_HIGH_BYTE: begin
          st_nxt.timer0_high_byte = sfr_wdata;
        end
        ADDR_TIMER1_LOW_BYTE: begin
          st_nxt.timer1_low_byte = sfr_wdata;
        end
        ADDR_TIMER1_HIGH_BYTE: begin
          st_nxt.timer1_high_byte = sfr_wdata;
        end
        ADDR_TIMER2_CONTROL: begin
          st_nxt.timer2_control = sfr_wdata;
        end
        ADDR_TIMER2_RELOAD_CAPTURE_LOW: begin
          st_nxt.reload_low = sfr_wdata;
        end
        ADDR_TIMER2_RELOAD_CAPTURE_HIGH: begin
          st_nxt.reload_high = sfr_wdata;
        end
        ADDR_TIMER2_COUNT_LOW: begin
          st_nxt.count[BYTE_W-1:0] = sfr_wdata;
        end
        ADDR_TIMER2_COUNT_HIGH: begin
          st_nxt.count[COUNT_W-1:BYTE_W] = sfr_wdata;
        end
        default: begin
          st_nxt.timer2_control = st_r.timer2_control;
        end
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (ovf_set) begin
      st_nxt.timer2_control[BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (ext_set) begin
      st_nxt.timer2_control[BIT_EXTERNAL_EVENT_FLAG] = 1'b1;
    end
    // Read data, registered
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_TIMER0_LOW_BYTE: st_nxt.rdata = st_r.timer0_low_byte;
        ADDR_TIMER0_HIGH_BYTE: st_nxt.rdata = st_r.timer0_high_byte;
        ADDR_TIMER1_LOW_BYTE: st_nxt.rdata = st_r.timer1_low_byte;
        ADDR_TIMER1_HIGH_BYTE: st_nxt.rdata = st_r.timer1_high_byte;
        ADDR_TIMER2_CONTROL: st_nxt.rdata = st_r.timer2_control;
        ADDR_TIMER2_RELOAD_CAPTURE_LOW: st_nxt.rdata = st_r.reload_low;
        ADDR_TIMER2_RELOAD_CAPTURE_HIGH: st_nxt.rdata = st_r.reload_high;
        ADDR_TIMER2_COUNT_LOW: st_nxt.rdata = st_r.count[BYTE_W-1:0];
        ADDR_TIMER2_COUNT_HIGH: st_nxt.rdata = st_r.count[COUNT_W-1:BYTE_W];
        default: st_nxt.rdata = READ_UNMAPPED;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{timer0_low_byte: RST_BYTE, timer0_high_byte: RST_BYTE,
                timer1_low_byte: RST_BYTE, timer1_high_byte: RST_BYTE,
                timer2_control: RST_BYTE, reload_low: RST_BYTE,
                reload_high: RST_BYTE, count: RST_COUNT, rdata: RST_BYTE,
                rx_tick: 1'b0, tx_tick: 1'b0,
                ovf_pulse: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata = st_r.rdata;
  assign rx_baud_tick = st_r.rx_tick;
  assign tx_baud_tick = st_r.tx_tick;
  assign overflow_flag = st_r.timer2_control[BIT_OVERFLOW_FLAG];
  assign external_event_flag = st_r.timer2_control[BIT_EXTERNAL_EVENT_FLAG];
  assign overflow_pulse = st_r.ovf_pulse;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic wr_ctrl;
  assign wr_ctrl = sfr_wr & (sfr_addr == ADDR_TIMER2_CONTROL);

  sequence s_ovf_normal;
    ovf && !baud_mode;
  endsequence

  sequence s_ext_edge;
    trig_edge;
  endsequence

  ovf_flag_set_a: assert property (s_ovf_normal |=> overflow_flag)
    else $error("overflow flag not set after overflow");

  ovf_flag_hold_a: assert property (
    overflow_flag && !wr_ctrl |=> overflow_flag)
    else $error("overflow flag cleared without a write");

  ovf_baud_block_a: assert property (
    !overflow_flag && baud_mode && !wr_ctrl |=> !overflow_flag)
    else $error("overflow flag set in baud mode");

  ext_flag_set_a: assert property (s_ext_edge |=> external_event_flag)
    else $error("external flag not set after trigger edge");

  ext_flag_hold_a: assert property (
    external_event_flag && !wr_ctrl |=> external_event_flag)
    else $error("external flag cleared without a write");

  rx_route_a: assert property (
    rx_sel |=> rx_baud_tick == $past(ovf))
    else $error("receive clock not from timer 2");

  rx_t1_route_a: assert property (
    !rx_sel |=> rx_baud_tick == $past(timer1_overflow))
    else $error("receive clock not from timer 1");

  tx_route_a: assert property (
    !tx_sel |=> tx_baud_tick == $past(timer1_overflow))
    else $error("transmit clock not from timer 1");

  tx_t2_route_a: assert property (
    tx_sel |=> tx_baud_tick == $past(ovf))
    else $error("transmit clock not from timer 2");

  trig_ignore_a: assert property (
    !trig_en && !run && !sfr_wr |=> $stable(st_r.count) && $stable(reload_val))
    else $error("trigger acted while disabled");

  run_stop_a: assert property (
    !run && !sfr_wr && !trig_edge |=> $stable(st_r.count))
    else $error("count moved while stopped");

  timer_count_a: assert property (
    run && !cnt_sel && !sfr_wr && !do_reload
    |=> st_r.count == $past(st_r.count) + COUNT_ONE)
    else $error("timer did not advance on the core clock");

  count_hold_a: assert property (
    run && cnt_sel && !pin_fall[PIN_COUNT] && !sfr_wr && !trig_edge |=> $stable(st_r.count))
    else $error("counter moved without a count pin edge");

  capture_a: assert property (
    do_capture && !sfr_wr |=> reload_val == $past(st_r.count))
    else $error("capture did not copy the count");

  reload_ovf_a: assert property (
    ovf && (baud_mode || !cap_sel) && !sfr_wr
    |=> st_r.count == $past(reload_val))
    else $error("overflow did not reload");

  baud_no_cap_a: assert property (
    trig_edge && baud_mode && !sfr_wr |=> $stable(reload_val))
    else $error("trigger captured in baud mode");

  ovf_pulse_a: assert property (
    overflow_pulse |-> $past(st_r.count) == COUNT_ALL_ONES && $past(run))
    else $error("overflow pulse without overflow");

  ovf_pulse_hit_a: assert property (
    run && !cnt_sel && st_r.count == COUNT_ALL_ONES |=> overflow_pulse)
    else $error("overflow gave no pulse");

endmodule : t2c_timer2

/* File: test/t2c_far_end.sv */
// Far side model: trigger and count pins, timer 1 overflow, serial tick counters
`timescale 1ns/1ns
module t2c_far_end (
  input wire logic clock, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  output logic trigger_input, // Trigger pin, idles high
  output logic count_input, // Count pin, idles high
  output logic timer1_overflow, // Timer 1 overflow pulse
  input wire logic rx_baud_tick, // Receive clock pulse from the block
  input wire logic tx_baud_tick, // Transmit clock pulse from the block
  output logic [15:0] rx_n, // Receive ticks seen
  output logic [15:0] tx_n // Transmit ticks seen
);
  // Pins idle high so no false edge is seen after reset
  initial begin
    trigger_input = 1'b1;
    count_input = 1'b1;
    timer1_overflow = 1'b0;
  end

  // Serial port side counts each one-cycle clock pulse
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_n <= 16'h0000;
      tx_n <= 16'h0000;
    end else begin
      rx_n <= rx_n + {15'h0000, rx_baud_tick};
      tx_n <= tx_n + {15'h0000, tx_baud_tick};
    end
  end

  // One falling edge, each level held three cycles for the synchroniser
  task automatic pin_fall(input bit on_count);
    @(negedge clock);
    if (on_count) begin
      count_input = 1'b0;
    end else begin
      trigger_input = 1'b0;
    end
    repeat (3) @(negedge clock);
    count_input = 1'b1;
    trigger_input = 1'b1;
    repeat (3) @(negedge clock);
  endtask : pin_fall

  // One timer 1 overflow pulse
  task automatic t1_pulse();
    @(negedge clock);
    timer1_overflow = 1'b1;
    @(negedge clock);
    timer1_overflow = 1'b0;
  endtask : t1_pulse
endmodule : t2c_far_end

/* File: test/t2c_timer2_tb.sv */
// Testbench for timer 2: registers, modes and serial clock routing
`timescale 1ns/1ns
module t2c_timer2_tb;
  import t2c_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic trigger_input, count_input, timer1_overflow;
  logic rx_baud_tick, tx_baud_tick, overflow_flag, external_event_flag, overflow_pulse;
  logic [15:0] rx_n, tx_n, n0, m0;
  logic [7:0] rv, rw;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int ovf_n = 0;
  int k0 = 0;
  logic [7:0] regs [9] = '{ADDR_TIMER0_LOW_BYTE, ADDR_TIMER1_LOW_BYTE,
    ADDR_TIMER0_HIGH_BYTE, ADDR_TIMER1_HIGH_BYTE, ADDR_TIMER2_CONTROL,
    ADDR_TIMER2_RELOAD_CAPTURE_LOW, ADDR_TIMER2_RELOAD_CAPTURE_HIGH,
    ADDR_TIMER2_COUNT_LOW, ADDR_TIMER2_COUNT_HIGH};

  // Clock and run limit
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    ovf_n <= ovf_n + int'(overflow_pulse);
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  t2c_timer2 t2c_timer2_inst (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .trigger_input(trigger_input), .count_input(count_input),
    .timer1_overflow(timer1_overflow), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .overflow_flag(overflow_flag),
    .external_event_flag(external_event_flag), .overflow_pulse(overflow_pulse));
  t2c_far_end t2c_far_end_inst (.clock(clock), .rst(rst), .trigger_input(trigger_input),
    .count_input(count_input), .timer1_overflow(timer1_overflow),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .rx_n(rx_n), .tx_n(tx_n));

  // ----------------------------------------------------------------
  // Bus tasks, comparison and verdict
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    check($sformatf("reg %h", a), {8'h00, rv}, {8'h00, exp});
  endtask : rdc
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    // Reset values, unmapped read, then plain storage
    foreach (regs[i]) rdc(regs[i], RST_BYTE);
    rdc(8'h90, READ_UNMAPPED);
    foreach (regs[i]) if (i != 4) wr(regs[i], 8'(8'h30 + i));
    foreach (regs[i]) if (i != 4) rdc(regs[i], 8'(8'h30 + i));
    // Timer overflow reloads the pair and sets the flag
    wr(ADDR_TIMER2_RELOAD_CAPTURE_LOW, 8'h34);
    wr(ADDR_TIMER2_RELOAD_CAPTURE_HIGH, 8'h12);
    wr(ADDR_TIMER2_COUNT_LOW, 8'hfd);
    wr(ADDR_TIMER2_COUNT_HIGH, 8'hff);
    check("ovf idle", overflow_flag, 1'b0);
    wr(ADDR_TIMER2_CONTROL, 8'h04);
    repeat (6) @(negedge clock);
    check("ovf set", overflow_flag, 1'b1);
    rdc(ADDR_TIMER2_CONTROL, 8'h84);
    rdc(ADDR_TIMER2_COUNT_HIGH, 8'h12);
    wr(ADDR_TIMER2_CONTROL, 8'h00);
    check("ovf clr", overflow_flag, 1'b0);
    rd(ADDR_TIMER2_COUNT_LOW, rw);
    rdc(ADDR_TIMER2_COUNT_LOW, rw);
    // Counter mode counts only count pin edges
    wr(ADDR_TIMER2_COUNT_LOW, 8'h00);
    wr(ADDR_TIMER2_CONTROL, 8'h06);
    repeat (3) t2c_far_end_inst.pin_fall(1'b1);
    rdc(ADDR_TIMER2_COUNT_LOW, 8'h03);
    // Capture on trigger edge
    wr(ADDR_TIMER2_COUNT_LOW, 8'hcd);
    wr(ADDR_TIMER2_COUNT_HIGH, 8'hab);
    wr(ADDR_TIMER2_CONTROL, 8'h0f);
    t2c_far_end_inst.pin_fall(1'b0);
    check("ext set", external_event_flag, 1'b1);
    rdc(ADDR_TIMER2_RELOAD_CAPTURE_LOW, 8'hcd);
    rdc(ADDR_TIMER2_RELOAD_CAPTURE_HIGH, 8'hab);
    rdc(ADDR_TIMER2_CONTROL, 8'h4f);
    // Reload on trigger edge
    wr(ADDR_TIMER2_CONTROL, 8'h0e);
    check("ext clr", external_event_flag, 1'b0);
    wr(ADDR_TIMER2_RELOAD_CAPTURE_LOW, 8'h55);
    wr(ADDR_TIMER2_RELOAD_CAPTURE_HIGH, 8'h66);
    t2c_far_end_inst.pin_fall(1'b0);
    rdc(ADDR_TIMER2_COUNT_LOW, 8'h55);
    rdc(ADDR_TIMER2_COUNT_HIGH, 8'h66);
    // Trigger ignored while its enable is off
    wr(ADDR_TIMER2_CONTROL, 8'h06);
    wr(ADDR_TIMER2_COUNT_LOW, 8'h00);
    t2c_far_end_inst.pin_fall(1'b0);
    rdc(ADDR_TIMER2_COUNT_LOW, 8'h00);
    rdc(ADDR_TIMER2_CONTROL, 8'h06);
    // Serial clocks from timer 1 when both selects are clear
    wr(ADDR_TIMER2_CONTROL, 8'h00);
    n0 = rx_n;
    m0 = tx_n;
    repeat (3) t2c_far_end_inst.t1_pulse();
    repeat (2) @(negedge clock);
    check("rx t1", rx_n - n0, 16'h0003);
    check("tx t1", tx_n - m0, 16'h0003);
    // Baud mode: capture select ignored, reload every two cycles, no overflow flag
    wr(ADDR_TIMER2_RELOAD_CAPTURE_LOW, 8'hfe);
    wr(ADDR_TIMER2_RELOAD_CAPTURE_HIGH, 8'hff);
    wr(ADDR_TIMER2_COUNT_LOW, 8'hfe);
    wr(ADDR_TIMER2_COUNT_HIGH, 8'hff);
    wr(ADDR_TIMER2_CONTROL, 8'h3d);
    n0 = rx_n;
    m0 = tx_n;
    k0 = ovf_n;
    repeat (40) @(negedge clock);
    check("rx t2", rx_n - n0, 16'h0013);
    check("tx t2", tx_n - m0, 16'h0013);
    check("ovf pulses", 16'(ovf_n - k0), 16'h0013);
    t2c_far_end_inst.pin_fall(1'b0);
    check("ovf baud", overflow_flag, 1'b0);
    rdc(ADDR_TIMER2_CONTROL, 8'h7d);
    rdc(ADDR_TIMER2_RELOAD_CAPTURE_LOW, 8'hfe);
    close_out();
  end
endmodule : t2c_timer2_tb
